// ==== logic/e1bp_timing.sv ====
// backplane sync, channel block and Sa link strobes of an e1 transceiver
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns
module e1bp_timing (
  // clock, reset, enable
  input  wire logic                clk_in,
  input  wire logic                srst_in,
  input  wire logic                ce_in,
  // register port
  input  wire e1bp_pkg::e1bp_bus_t bus_in,
  output logic [7:0]               rd_data_out,
  // link clocks, sampled
  input  wire logic                rx_bit_clock_in,
  input  wire logic                tx_bit_clock_in,
  input  wire logic                backplane_clock_in,
  // receive side
  input  wire logic                rx_serial_data_in,
  input  wire logic                rx_sync_pin_in,
  output logic                     rx_sync_pin_out,
  output logic                     rx_sync_pin_oe_out,
  output logic                     rx_serial_data_out,
  output logic                     rx_channel_clock_out,
  output logic                     rx_channel_block_out,
  output logic                     rx_link_clock_out,
  output logic                     rx_link_data_out,
  // transmit side
  input  wire logic                tx_serial_data_in,
  input  wire logic                tx_link_data_in,
  input  wire logic                tx_sync_pin_in,
  output logic                     tx_sync_pin_out,
  output logic                     tx_sync_pin_oe_out,
  output logic                     tx_channel_clock_out,
  output logic                     tx_channel_block_out,
  output logic                     tx_link_clock_out,
  output logic                     tx_line_data_out
);
  import e1bp_pkg::*;

  e1bp_state_t s_ff;
  e1bp_state_t nxt_s;

  logic rx_rise;
  logic rx_fall;
  logic tx_rise;
  logic tx_fall;
  logic bp_rise;
  logic bp_fall;
  logic t1_mode;
  logic es_mode;
  logic g8_mode;
  logic [7:0] bp_q;
  logic [4:0] bp_ts;

  // selected Sa bit of a non-align frame
  function automatic logic sa_hit(input logic [11:0] pos, input logic [7:0] mask);
    logic [2:0] idx;
    idx = pos[2:0] - SA4_BIT;
    sa_hit = pos[8] && (pos[7:3] == SA_TS) && (pos[2:0] >= SA4_BIT) && mask[idx];
  endfunction

  // per-timeslot block or fixed pattern
  function automatic logic blk_hit(input logic [4:0] ts, input logic [2:0] bit_n,
                                   input logic [31:0] map, input logic g8);
    logic in_a;
    logic in_b;
    in_a = (ts >= G8_LO_A) && (ts <= G8_HI_A);
    in_b = (ts >= G8_LO_B) && (ts <= G8_HI_B);
    if (g8) begin
      blk_hit = in_a || in_b || ((ts == G8_PART_TS) && (bit_n == 3'h0));
    end else begin
      blk_hit = map[ts];
    end
  endfunction

  // sync start of frame or multiframe
  function automatic logic at_start(input logic [11:0] pos, input logic mf);
    at_start = (pos[7:0] == FRAME_START) && (!mf || (pos[11:8] == MF_START));
  endfunction

  // edge finders on the second and third stages
  assign rx_rise = s_ff.in_s2[SI_RXCLK] & ~s_ff.in_s3[SI_RXCLK];
  assign rx_fall = ~s_ff.in_s2[SI_RXCLK] & s_ff.in_s3[SI_RXCLK];
  assign tx_rise = s_ff.in_s2[SI_TXCLK] & ~s_ff.in_s3[SI_TXCLK];
  assign tx_fall = ~s_ff.in_s2[SI_TXCLK] & s_ff.in_s3[SI_TXCLK];
  assign bp_rise = s_ff.in_s2[SI_BPCLK] & ~s_ff.in_s3[SI_BPCLK];
  assign bp_fall = ~s_ff.in_s2[SI_BPCLK] & s_ff.in_s3[SI_BPCLK];

  // mode bits
  assign t1_mode = s_ff.mode[MODE_T1_BIT];
  assign es_mode = s_ff.mode[MODE_ES_BIT];
  assign g8_mode = s_ff.mode[MODE_G8_BIT];

  // next state
  always_comb begin
    nxt_s = s_ff;
    bp_q  = 8'h00;
    bp_ts = 5'h00;

    // pin synchronisers
    nxt_s.in_s1 = {tx_link_data_in, tx_serial_data_in, rx_serial_data_in,
                   tx_sync_pin_in, rx_sync_pin_in, backplane_clock_in,
                   tx_bit_clock_in, rx_bit_clock_in};
    nxt_s.in_s2 = s_ff.in_s1;
    nxt_s.in_s3 = s_ff.in_s2;

    // register writes
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        REG_RX_CTL: begin
          nxt_s.rx_ctl = bus_in.wdata;
        end
        REG_TX_CTL: begin
          nxt_s.tx_ctl = bus_in.wdata;
        end
        REG_RX_SA: begin
          nxt_s.rx_sa = {3'h0, bus_in.wdata[4:0]};
        end
        REG_TX_SA: begin
          nxt_s.tx_sa = {3'h0, bus_in.wdata[4:0]};
        end
        REG_MODE: begin
          nxt_s.mode = {5'h00, bus_in.wdata[2:0]};
        end
        4'h5, 4'h6, 4'h7, 4'h8: begin
          nxt_s.rx_map[8*(bus_in.addr - REG_RX_MAP0) +: 8] = bus_in.wdata;
        end
        4'h9, 4'hA, 4'hB, 4'hC: begin
          nxt_s.tx_map[8*(bus_in.addr - REG_TX_MAP0) +: 8] = bus_in.wdata;
        end
        default: begin
        end
      endcase
    end

    // register reads, data only in the following cycle
    nxt_s.rd_data = 8'h00;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        REG_RX_CTL: nxt_s.rd_data = s_ff.rx_ctl;
        REG_TX_CTL: nxt_s.rd_data = s_ff.tx_ctl;
        REG_RX_SA:  nxt_s.rd_data = s_ff.rx_sa;
        REG_TX_SA:  nxt_s.rd_data = s_ff.tx_sa;
        REG_MODE:   nxt_s.rd_data = s_ff.mode;
        4'h5, 4'h6, 4'h7, 4'h8: begin
          nxt_s.rd_data = s_ff.rx_map[8*(bus_in.addr - REG_RX_MAP0) +: 8];
        end
        4'h9, 4'hA, 4'hB, 4'hC: begin
          nxt_s.rd_data = s_ff.tx_map[8*(bus_in.addr - REG_TX_MAP0) +: 8];
        end
        REG_STATUS: nxt_s.rd_data = {s_ff.rx_pos[11:8], s_ff.tx_pos[11:8]};
        default:    nxt_s.rd_data = 8'h00;
      endcase
    end

    // R2: sync pin direction
    nxt_s.rx_sync_oe = ~s_ff.rx_ctl[RX_DIR_BIT];
    // R4: sync pin direction
    nxt_s.tx_sync_oe = s_ff.tx_ctl[TX_DIR_BIT];

    // receive bit position and strobes on the rising edge
    if (rx_rise) begin
      nxt_s.rx_pos = s_ff.rx_pos + 12'h001;
      // R1: frame or multiframe sync
      // R11: one bit on the first bit
      nxt_s.rx_sync_o = ~s_ff.rx_ctl[RX_DIR_BIT]
                        && at_start(nxt_s.rx_pos, s_ff.rx_ctl[RX_MF_BIT]);
      nxt_s.rx_chclk  = (nxt_s.rx_pos[2:0] == 3'h0);
      // R9: rx channel block
      nxt_s.rx_blk    = blk_hit(nxt_s.rx_pos[7:3], nxt_s.rx_pos[2:0],
                                s_ff.rx_map, g8_mode);
      // R7: link clock at chosen Sa
      nxt_s.rx_lclk   = sa_hit(nxt_s.rx_pos, s_ff.rx_sa);
    end

    // receive sampling on the falling edge
    if (rx_fall) begin
      nxt_s.rx_sync_prev = s_ff.in_s2[SI_RXSYNC];
      // R2: external sync realigns the count
      if (s_ff.rx_ctl[RX_DIR_BIT] && s_ff.in_s2[SI_RXSYNC] && !s_ff.rx_sync_prev) begin
        nxt_s.rx_pos[7:0] = FRAME_START;
        if (s_ff.rx_ctl[RX_MF_BIT]) begin
          nxt_s.rx_pos[11:8] = MF_START;
        end
      end
      nxt_s.frame_buf[nxt_s.rx_pos[7:0]] = s_ff.in_s2[SI_RXSER];
      // R6: whole stream on link data
      nxt_s.rx_ldata = s_ff.in_s2[SI_RXSER];
    end

    // backplane side read-out of the frame buffer
    if (bp_rise) begin
      if (t1_mode && (s_ff.bp_pos == T1_LAST_BIT)) begin
        nxt_s.bp_pos = FRAME_START;
      end else begin
        nxt_s.bp_pos = s_ff.bp_pos + 8'h01;
      end
      bp_q  = nxt_s.bp_pos - 8'h01;
      bp_ts = bp_q[7:3] + (bp_q[7:3] / 5'd3) + 5'd1;
      // R5: drop every fourth channel, F bit high
      if (!t1_mode) begin
        nxt_s.rx_ser = s_ff.frame_buf[nxt_s.bp_pos];
      end else if (nxt_s.bp_pos == FRAME_START) begin
        nxt_s.rx_ser = 1'b1;
      end else begin
        nxt_s.rx_ser = s_ff.frame_buf[{bp_ts, bp_q[2:0]}];
      end
    end

    // R10: elastic store takes data on backplane fall
    if (bp_fall && es_mode) begin
      nxt_s.tx_hold = s_ff.in_s2[SI_TXSER];
    end

    // transmit position and strobes on the rising edge
    if (tx_rise) begin
      nxt_s.tx_pos = s_ff.tx_pos + 12'h001;
      // R3: frame or multiframe sync
      // R11: one bit on the first bit
      nxt_s.tx_sync_o = s_ff.tx_ctl[TX_DIR_BIT]
                        && at_start(nxt_s.tx_pos, s_ff.tx_ctl[TX_MF_BIT]);
      nxt_s.tx_chclk  = (nxt_s.tx_pos[2:0] == 3'h0);
      // R9: tx channel block
      nxt_s.tx_blk    = blk_hit(nxt_s.tx_pos[7:3], nxt_s.tx_pos[2:0],
                                s_ff.tx_map, g8_mode);
      nxt_s.tx_lclk   = sa_hit(nxt_s.tx_pos, s_ff.tx_sa);
    end

    // transmit sampling on the falling edge
    if (tx_fall) begin
      nxt_s.tx_sync_prev = s_ff.in_s2[SI_TXSYNC];
      // R4: backplane sync realigns the count
      if (!s_ff.tx_ctl[TX_DIR_BIT] && s_ff.in_s2[SI_TXSYNC] && !s_ff.tx_sync_prev) begin
        nxt_s.tx_pos[7:0] = FRAME_START;
        if (s_ff.tx_ctl[TX_MF_BIT]) begin
          nxt_s.tx_pos[11:8] = MF_START;
        end
      end
      // R8: link data only at chosen Sa
      if (sa_hit(nxt_s.tx_pos, s_ff.tx_sa)) begin
        nxt_s.tx_line = s_ff.in_s2[SI_TXLINK];
      end else if (es_mode) begin
        // R10: data from the backplane sample
        nxt_s.tx_line = s_ff.tx_hold;
      end else begin
        nxt_s.tx_line = s_ff.in_s2[SI_TXSER];
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_ff        <= '0;
      s_ff.rx_ctl <= RX_CTL_RST;
      s_ff.tx_ctl <= TX_CTL_RST;
      s_ff.rx_sa  <= SA_RST;
      s_ff.tx_sa  <= SA_RST;
      s_ff.mode   <= MODE_RST;
      s_ff.rx_map <= MAP_RST;
      s_ff.tx_map <= MAP_RST;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state
  assign rd_data_out          = s_ff.rd_data;
  assign rx_sync_pin_out      = s_ff.rx_sync_o;
  assign rx_sync_pin_oe_out   = s_ff.rx_sync_oe;
  assign rx_serial_data_out   = s_ff.rx_ser;
  assign rx_channel_clock_out = s_ff.rx_chclk;
  assign rx_channel_block_out = s_ff.rx_blk;
  assign rx_link_clock_out    = s_ff.rx_lclk;
  assign rx_link_data_out     = s_ff.rx_ldata;
  assign tx_sync_pin_out      = s_ff.tx_sync_o;
  assign tx_sync_pin_oe_out   = s_ff.tx_sync_oe;
  assign tx_channel_clock_out = s_ff.tx_chclk;
  assign tx_channel_block_out = s_ff.tx_blk;
  assign tx_link_clock_out    = s_ff.tx_lclk;
  assign tx_line_data_out     = s_ff.tx_line;

endmodule // e1bp_timing

// ==== logic/e1bp_pkg.sv ====
// constants, bus carrier and state record of the e1 backplane timing block
// Contract
// R1: rx sync marks frames when its mode bit is 0, multiframes when 1.
// R2: rx sync pin is driven when direction bit is 0, input when 1.
// R3: tx sync refers to frames when its mode bit is 0, multiframes when 1.
// R4: tx sync pin is input when direction bit is 0, driven when 1.
// R5: 1.544 MHz backplane drops every fourth E1 channel, adds F bit at one.
// R6: rx link data carries the whole received stream, all Sa bits included.
// R7: rx link clock pulses only at the selected Sa bit positions.
// R8: tx link data is sampled only at the selected Sa bit positions.
// R9: channel block outputs follow a per-timeslot map or the G.802 pattern.
// R10: with tx elastic store on, tx serial sampled on backplane clock fall.
// R11: a driven sync pulse lasts one bit and sits on the first bit.
package e1bp_pkg;

  // register offsets
  localparam logic [3:0] REG_RX_CTL  = 4'h0;
  localparam logic [3:0] REG_TX_CTL  = 4'h1;
  localparam logic [3:0] REG_RX_SA   = 4'h2;
  localparam logic [3:0] REG_TX_SA   = 4'h3;
  localparam logic [3:0] REG_MODE    = 4'h4;
  localparam logic [3:0] REG_RX_MAP0 = 4'h5;
  localparam logic [3:0] REG_TX_MAP0 = 4'h9;
  localparam logic [3:0] REG_STATUS  = 4'hD;

  // field positions
  localparam int RX_MF_BIT   = 6;
  localparam int RX_DIR_BIT  = 5;
  localparam int TX_MF_BIT   = 1;
  localparam int TX_DIR_BIT  = 0;
  localparam int MODE_T1_BIT = 0;
  localparam int MODE_ES_BIT = 1;
  localparam int MODE_G8_BIT = 2;

  // reset values
  localparam logic [7:0]  RX_CTL_RST = 8'h00;
  localparam logic [7:0]  TX_CTL_RST = 8'h00;
  localparam logic [7:0]  SA_RST     = 8'h01;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [31:0] MAP_RST    = 32'h0000_0000;

  // frame geometry
  localparam logic [7:0] T1_LAST_BIT = 8'hC0;
  localparam logic [7:0] FRAME_START = 8'h00;
  localparam logic [3:0] MF_START    = 4'h0;
  localparam logic [3:0] MF_LAST     = 4'hF;
  localparam logic [2:0] SA4_BIT     = 3'h3;
  localparam logic [4:0] SA_TS       = 5'h00;
  localparam logic [4:0] G8_LO_A     = 5'h01;
  localparam logic [4:0] G8_HI_A     = 5'h0F;
  localparam logic [4:0] G8_LO_B     = 5'h11;
  localparam logic [4:0] G8_HI_B     = 5'h19;
  localparam logic [4:0] G8_PART_TS  = 5'h1A;

  // synchroniser lanes
  localparam int SI_RXCLK  = 0;
  localparam int SI_TXCLK  = 1;
  localparam int SI_BPCLK  = 2;
  localparam int SI_RXSYNC = 3;
  localparam int SI_TXSYNC = 4;
  localparam int SI_RXSER  = 5;
  localparam int SI_TXSER  = 6;
  localparam int SI_TXLINK = 7;
  localparam int SI_W      = 8;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } e1bp_bus_t;

  // whole state of the block
  typedef struct packed {
    logic [SI_W-1:0] in_s1;
    logic [SI_W-1:0] in_s2;
    logic [SI_W-1:0] in_s3;
    logic [7:0]      rx_ctl;
    logic [7:0]      tx_ctl;
    logic [7:0]      rx_sa;
    logic [7:0]      tx_sa;
    logic [7:0]      mode;
    logic [31:0]     rx_map;
    logic [31:0]     tx_map;
    logic [7:0]      rd_data;
    logic [11:0]     rx_pos;
    logic [11:0]     tx_pos;
    logic [7:0]      bp_pos;
    logic            rx_sync_prev;
    logic            tx_sync_prev;
    logic [255:0]    frame_buf;
    logic            tx_hold;
    logic            rx_sync_o;
    logic            rx_sync_oe;
    logic            tx_sync_o;
    logic            tx_sync_oe;
    logic            rx_chclk;
    logic            rx_blk;
    logic            rx_lclk;
    logic            rx_ldata;
    logic            rx_ser;
    logic            tx_chclk;
    logic            tx_blk;
    logic            tx_lclk;
    logic            tx_line;
  } e1bp_state_t;

endpackage

// ==== sim/e1bp_timing_properties.sv ====
// concurrent checks on the ports of the e1 backplane timing block
`timescale 1ns/1ns
module e1bp_chk (
  // clock, reset, enable
  input wire logic                clk_in,
  input wire logic                srst_in,
  input wire logic                ce_in,
  // register port
  input wire e1bp_pkg::e1bp_bus_t bus_in,
  input wire logic [7:0]          rd_data_out,
  // sync pins and link strobes
  input wire logic                rx_sync_pin_out,
  input wire logic                rx_sync_pin_oe_out,
  input wire logic                tx_sync_pin_out,
  input wire logic                tx_sync_pin_oe_out,
  input wire logic                rx_link_clock_out,
  input wire logic                tx_link_clock_out
);
  import e1bp_pkg::*;
  logic [1:0] age_ff;
  logic       rdir_ff;
  logic       tdir_ff;
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (srst_in || !ce_in);
  // last written direction bits and cycles since
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      age_ff <= 2'h0;
      rdir_ff <= 1'b0;
      tdir_ff <= 1'b0;
    end else if (ce_in && bus_in.wr && bus_in.addr == REG_RX_CTL) begin
      age_ff <= 2'h0;
      rdir_ff <= bus_in.wdata[RX_DIR_BIT];
    end else if (ce_in && bus_in.wr && bus_in.addr == REG_TX_CTL) begin
      age_ff <= 2'h0;
      tdir_ff <= bus_in.wdata[TX_DIR_BIT];
    end else if (age_ff != 2'h3) begin
      age_ff <= age_ff + 2'h1;
    end
  end
  // read data stands one cycle only
  a_rd_idle_zero: assert property ($past(ce_in) && !$past(bus_in.rd) |-> rd_data_out == 8'h00)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property ($past(bus_in.rd && ce_in) && $past(bus_in.addr) > REG_STATUS
    |-> rd_data_out == 8'h00) else $error("unmapped read not zero");
  a_wr_rd_back: assert property ($past(bus_in.wr, 2) && $past(bus_in.rd) && $past(ce_in, 2)
    && $past(bus_in.addr, 2) == $past(bus_in.addr) && $past(bus_in.addr) <= 4'hC
    |-> rd_data_out == $past(bus_in.wdata, 2)) else $error("write then read mismatch");
  a_rx_oe_dir: assert property (age_ff == 2'h3 |-> rx_sync_pin_oe_out == !rdir_ff)
    else $error("rx sync enable wrong");
  a_tx_oe_dir: assert property (age_ff == 2'h3 |-> tx_sync_pin_oe_out == tdir_ff)
    else $error("tx sync enable wrong");
  a_rx_sync_len: assert property ($rose(rx_sync_pin_out) && rx_sync_pin_oe_out |->
    rx_sync_pin_out[*8] ##1 rx_sync_pin_out[*6] ##[1:4] !rx_sync_pin_out)
    else $error("rx sync pulse length wrong");
  a_tx_sync_len: assert property ($rose(tx_sync_pin_out) && tx_sync_pin_oe_out |->
    tx_sync_pin_out[*8] ##1 tx_sync_pin_out[*6] ##[1:4] !tx_sync_pin_out)
    else $error("tx sync pulse length wrong");
  a_rx_lclk_bit: assert property ($fell(rx_link_clock_out) |->
    $past(rx_link_clock_out, 16) && !$past(rx_link_clock_out, 17))
    else $error("rx link strobe width wrong");
  a_tx_lclk_bit: assert property ($fell(tx_link_clock_out) |->
    $past(tx_link_clock_out, 16) && !$past(tx_link_clock_out, 17))
    else $error("tx link strobe width wrong");
endmodule // e1bp_chk

bind e1bp_timing e1bp_chk u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .bus_in(bus_in),
  .rd_data_out(rd_data_out), .rx_sync_pin_out(rx_sync_pin_out),
  .rx_sync_pin_oe_out(rx_sync_pin_oe_out), .tx_sync_pin_out(tx_sync_pin_out),
  .tx_sync_pin_oe_out(tx_sync_pin_oe_out), .rx_link_clock_out(rx_link_clock_out),
  .tx_link_clock_out(tx_link_clock_out)
);

// ==== sim/e1bp_partner.sv ====
// line and backplane model: bit clocks, serial data, sync pulses
`timescale 1ns/1ns
module e1bp_partner (
  // clocks
  output logic rx_clk_out,
  output logic tx_clk_out,
  output logic bp_clk_out,
  // data and sync
  output logic rx_ser_out,
  output logic rx_sync_out,
  output logic tx_ser_out,
  output logic tx_link_out,
  output logic tx_sync_out
);
  logic [7:0] rpos = 8'h00;
  logic [7:0] tpos = 8'h00;
  // free running clocks, fixed phases, 64 ns
  initial begin
    rx_clk_out = 1'b0;
    #1;
    forever #32 rx_clk_out = ~rx_clk_out;
  end
  initial begin
    bp_clk_out = 1'b0;
    #3;
    forever #32 bp_clk_out = ~bp_clk_out;
  end
  initial begin
    tx_clk_out = 1'b0;
    #19;
    forever #32 tx_clk_out = ~tx_clk_out;
  end
  // high across backplane fall, low at tx fall
  initial begin
    tx_ser_out = 1'b0;
    #11;
    forever #32 tx_ser_out = ~tx_ser_out;
  end
  // bit positions, changed after each rise
  always @(posedge rx_clk_out) rpos <= rpos + 8'h01;
  always @(posedge tx_clk_out) tpos <= tpos + 8'h01;
  // ones in Sa bits, ts4 and ts5
  assign rx_ser_out = (rpos[7:3] == 5'h00 && rpos[2:0] >= 3'h3) || rpos[7:4] == 4'h2;
  assign rx_sync_out = rpos == 8'h00;
  assign tx_sync_out = tpos == 8'h00;
  // link data present at every bit
  assign tx_link_out = 1'b1;
endmodule // e1bp_partner

// ==== sim/e1bp_timing_tb.sv ====
// self checking bench for the e1 backplane timing block
`timescale 1ns/1ns
module e1bp_timing_tb;
  import e1bp_pkg::*;
  logic       clk_in = 1'b0;
  logic       srst_in = 1'b1;
  logic       ce_in = 1'b1;
  e1bp_bus_t  bus = '0;
  logic [7:0] rd_data;
  logic       rxc, txc, bpc, rxd, rxs, txd, txl, txs, rx_oe, tx_oe;
  wire  [10:0] mon;
  logic       rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] lfsr = 8'h57;
  logic [63:0] maps;
  int         miscompares = 0;
  int         num_checks = 0;
  int         hi[11];
  int         ri[11];
  wire rxs_w = (rx_oe === 1'b1) ? mon[8] : rxs;
  wire txs_w = (tx_oe === 1'b1) ? mon[9] : txs;
  // clock
  initial forever #2 clk_in = ~clk_in;
  e1bp_partner u_part (.rx_clk_out(rxc), .tx_clk_out(txc), .bp_clk_out(bpc),
    .rx_ser_out(rxd), .rx_sync_out(rxs), .tx_ser_out(txd), .tx_link_out(txl),
    .tx_sync_out(txs));
  e1bp_timing dut (
    .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .bus_in(bus),
    .rd_data_out(rd_data), .rx_bit_clock_in(rxc), .tx_bit_clock_in(txc),
    .backplane_clock_in(bpc), .rx_serial_data_in(rxd), .rx_sync_pin_in(rxs_w),
    .rx_sync_pin_out(mon[8]), .rx_sync_pin_oe_out(rx_oe), .rx_serial_data_out(mon[0]),
    .rx_channel_clock_out(mon[4]), .rx_channel_block_out(mon[3]),
    .rx_link_clock_out(mon[2]), .rx_link_data_out(mon[1]), .tx_serial_data_in(txd),
    .tx_link_data_in(txl), .tx_sync_pin_in(txs_w), .tx_sync_pin_out(mon[9]),
    .tx_sync_pin_oe_out(tx_oe), .tx_channel_clock_out(mon[6]),
    .tx_channel_block_out(mon[5]), .tx_link_clock_out(mon[10]),
    .tx_line_data_out(mon[7]));
  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    report(32'(got), 32'(exp));
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    report(got, exp);
  endtask
  // bus cycles, one strobe per cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
  endtask
  // high samples and rises of each of the 11 outputs in mon over n cycles
  task automatic count(input int n);
    logic [10:0] p;
    bus <= '0;
    p = mon;
    hi = '{default: 0};
    ri = '{default: 0};
    repeat (n) begin
      @(posedge clk_in);
      for (int i = 0; i < 11; i++) begin
        hi[i] += int'(mon[i] === 1'b1);
        ri[i] += int'(mon[i] === 1'b1 && p[i] === 1'b0);
      end
      p = mon;
    end
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // read answers taken one cycle after the strobe
  always @(posedge clk_in) begin
    if (rd_seen) cmp_rd(rd_data, exp_q.pop_front());
    rd_seen <= bus.rd && ce_in && !srst_in;
  end
  // watchdog
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(REG_RX_CTL, RX_CTL_RST);
    rd(REG_TX_CTL, TX_CTL_RST);
    rd(REG_RX_SA, SA_RST);
    rd(REG_TX_SA, SA_RST);
    rd(REG_MODE, MODE_RST);
    for (int i = 0; i < 8; i++) begin
      rd(REG_RX_MAP0 + 4'(i), MAP_RST[7:0]);
      lfsr = lfsr_step(lfsr);
      maps[i*8 +: 8] = lfsr;
      wr(REG_RX_MAP0 + 4'(i), lfsr);
      rd(REG_RX_MAP0 + 4'(i), lfsr);
    end
    wr(4'hE, 8'hA5);
    rd(4'hE, 8'h00);
    ce_in <= 1'b0;
    wr(REG_RX_SA, 8'h1F);
    ce_in <= 1'b1;
    rd(REG_RX_SA, SA_RST);
    wr(REG_RX_SA, 8'h11);
    wr(REG_TX_SA, 8'h14);
    wr(REG_TX_CTL, 8'h03);
    count(4096);
    count(8192);
    cmp_cnt(ri[8], 2);
    cmp_cnt(int'(ri[9] < 2), 1);
    cmp_cnt(hi[1], 672);
    cmp_cnt(hi[2], 32);
    cmp_cnt(hi[3], $countones(maps[31:0]) * 256);
    cmp_cnt(hi[5], $countones(maps[63:32]) * 256);
    cmp_cnt(hi[7], 32);
    cmp_cnt(hi[10], 32);
    // multiframe rx, frame tx, block pattern
    wr(REG_RX_CTL, 8'h40);
    wr(REG_TX_CTL, 8'h01);
    wr(REG_MODE, 8'h04);
    // settle so no old map pattern or old sync mode leaks into the window
    count(4096);
    count(8192);
    cmp_cnt(int'(ri[8] < 2), 1);
    cmp_cnt(ri[9], 2);
    cmp_cnt(hi[3], 6176);
    cmp_cnt(hi[5], 6176);
    // input sync aligns the narrow backplane map
    wr(REG_RX_CTL, 8'h20);
    wr(REG_MODE, 8'h01);
    count(8192);
    count(3088);
    cmp_cnt(hi[0], 144);
    // elastic store takes backplane fall sample
    wr(REG_TX_SA, 8'h00);
    wr(REG_MODE, 8'h02);
    count(256);
    count(4096);
    cmp_cnt(hi[7], 4096);
    conclude();
  end
endmodule // e1bp_timing_tb
